// >>> rtl/ecd_pkg.sv
package ecd_pkg;
	// Register offsets on the device's own byte-wide port
	localparam logic [1:0] ECD_OFF_POLICY = 2'h0;
	localparam logic [1:0] ECD_OFF_DMA = 2'h1;
	// APB word offsets of the controller's own registers
	localparam logic [7:0] ECD_APB_CMD = 8'h00;
	localparam logic [7:0] ECD_APB_STATUS = 8'h04;
	localparam logic [7:0] ECD_APB_IRQ_STATUS = 8'h08;
	localparam logic [7:0] ECD_APB_IRQ_MASK = 8'h0c;
	// Policy field codes
	localparam logic [2:0] ECD_POL_AUTO_RETRY = 3'h6;
	localparam logic [2:0] ECD_POL_AUTO_SKIP = 3'h7;
	localparam logic [2:0] ECD_POL_RESUME_RETRY = 3'h2;
	localparam logic [2:0] ECD_POL_RESUME_SKIP = 3'h3;
	// Field positions in the DMA enable register
	localparam int ECD_BIT_DMA_WR = 0;
	localparam int ECD_BIT_DMA_RD = 1;
	localparam int ECD_BIT_OVERSIZE = 3;
	// Reset values
	localparam logic [7:0] ECD_POLICY_RST = 8'h00;
	localparam logic [7:0] ECD_DMA_RST = 8'h00;
	// Packet length limits
	localparam logic [10:0] ECD_OVERSIZE_LEN = 11'h700;
	localparam logic [10:0] ECD_MAX_LEN = 11'h7ff;
	// Outcome of a sixteen collision event
	typedef enum logic [1:0] {
		ECD_ACT_NONE = 2'b00,
		ECD_ACT_RETRY = 2'b01,
		ECD_ACT_SKIP = 2'b10
	} ecd_act_t;
endpackage

// >>> rtl/ecd_if.sv
`timescale 1ns/1ps
`default_nettype none
// Byte-wide register port between host controller and device
interface ecd_if;
	logic sel;
	logic wr;
	logic [1:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport dev (input sel, input wr, input addr, input wdata, output rdata);
	modport host (output sel, output wr, output addr, output wdata, input rdata);
endinterface
`default_nettype wire

// >>> rtl/ecd_device.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Policy bits 7..3 read zero, write zero
// - Code 110 retries automatically after sixteen collisions
// - Code 111 drops packet, sends next automatically
// - Code 01x halts transmitter on sixteen collisions
// - Resume code acts only when written
// - Resume 010 retransmits the halted packet
// - Resume 011 drops halted packet, sends next
// - DMA register bits 7..4 undefined, write zero
// - Oversize removal rejects packets of 1792+ bytes
// - Removal disabled passes packets up to 2047
// - DMA register bit 2 reads zero
// - Read enable gates host DMA reads
// - Write enable gates host DMA writes
// - Writing both enables zero clears end flag
// - Software never sets both enables together
// - Software keeps enables zero in card mode; host zeroes them only in DMA writes issued in card mode
// - Pending count decrements per handled packet
module ecd_device (
	input wire logic clk_i,
	input wire logic reset_n_i,
	ecd_if.dev bus,
	input wire logic sixteen_collision_event_i,
	input wire logic tx_done_i,
	input wire logic tx_start_i,
	input wire logic [6:0] tx_count_i,
	input wire logic dma_end_i,
	input wire logic rx_len_valid_i,
	input wire logic [10:0] rx_len_i,
	input wire logic dma_rd_req_i,
	input wire logic dma_wr_req_i,
	output logic tx_halted_o,
	output logic [1:0] collision_action_o,
	output logic [6:0] pending_tx_count_o,
	output logic dma_end_flag_o,
	output logic rx_accept_o,
	output logic rx_reject_o,
	output logic dma_rd_grant_o,
	output logic dma_wr_grant_o
);
	import ecd_pkg::*;

	typedef struct packed {
		logic [2:0] excess_collision_policy_field;
		logic oversize_removal_disable;
		logic dma_read_enable;
		logic dma_write_enable;
		logic halted;
		logic [1:0] act;
		logic [6:0] pending;
		logic end_flag;
		logic rx_ok;
		logic rx_bad;
	} ecd_dev_state_t;

	ecd_dev_state_t st_reg, st_next;
	logic wr_pol, wr_dma, done_any;

	assign wr_pol = bus.sel && bus.wr && bus.addr == ECD_OFF_POLICY;
	assign wr_dma = bus.sel && bus.wr && bus.addr == ECD_OFF_DMA;

	// Next-state logic for the whole device
	always_comb begin
		st_next = st_reg;
		st_next.act = ECD_ACT_NONE;
		st_next.rx_ok = 1'b0;
		st_next.rx_bad = 1'b0;
		done_any = tx_done_i;
		if (wr_pol) begin
			st_next.excess_collision_policy_field = bus.wdata[2:0];
		end
		// Resume codes take effect only on the write itself
		if (wr_pol && st_reg.halted) begin
			if (bus.wdata[2:0] == ECD_POL_RESUME_RETRY) begin
				st_next.halted = 1'b0;
				st_next.act = ECD_ACT_RETRY;
			end else if (bus.wdata[2:0] == ECD_POL_RESUME_SKIP) begin
				st_next.halted = 1'b0;
				st_next.act = ECD_ACT_SKIP;
				done_any = 1'b1;
			end
		end else if (sixteen_collision_event_i && !st_reg.halted) begin
			if (st_reg.excess_collision_policy_field == ECD_POL_AUTO_RETRY) begin
				st_next.act = ECD_ACT_RETRY;
			end else if (st_reg.excess_collision_policy_field == ECD_POL_AUTO_SKIP) begin
				st_next.act = ECD_ACT_SKIP;
				done_any = 1'b1;
			end else if (st_reg.excess_collision_policy_field[2:1] == 2'b01) begin
				st_next.halted = 1'b1;
			end else begin
				st_next.act = ECD_ACT_RETRY;
			end
		end
		// Packet count, skipped packets count as handled
		if (tx_start_i) begin
			st_next.pending = tx_count_i;
		end else if (done_any && st_reg.pending != 7'h00) begin
			st_next.pending = st_reg.pending - 7'h01;
		end
		if (wr_dma) begin
			st_next.oversize_removal_disable = bus.wdata[ECD_BIT_OVERSIZE];
			st_next.dma_read_enable = bus.wdata[ECD_BIT_DMA_RD];
			st_next.dma_write_enable = bus.wdata[ECD_BIT_DMA_WR];
		end
		// Set wins over clear so an end event is never lost
		if (dma_end_i) begin
			st_next.end_flag = 1'b1;
		end else if (wr_dma && bus.wdata[1:0] == 2'b00) begin
			st_next.end_flag = 1'b0;
		end
		if (rx_len_valid_i) begin
			if (!st_reg.oversize_removal_disable && rx_len_i >= ECD_OVERSIZE_LEN) begin
				st_next.rx_bad = 1'b1;
			end else if (rx_len_i > ECD_MAX_LEN) begin
				st_next.rx_bad = 1'b1;
			end else begin
				st_next.rx_ok = 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Read mux; unused high bits of the DMA register read zero here
	always_comb begin
		bus.rdata = 8'h00;
		if (bus.addr == ECD_OFF_POLICY) begin
			bus.rdata = {5'h00, st_reg.excess_collision_policy_field};
		end else if (bus.addr == ECD_OFF_DMA) begin
			bus.rdata = {4'h0, st_reg.oversize_removal_disable, 1'b0,
				st_reg.dma_read_enable, st_reg.dma_write_enable};
		end
	end

	assign tx_halted_o = st_reg.halted;
	assign collision_action_o = st_reg.act;
	assign pending_tx_count_o = st_reg.pending;
	assign dma_end_flag_o = st_reg.end_flag;
	assign rx_accept_o = st_reg.rx_ok;
	assign rx_reject_o = st_reg.rx_bad;
	// Host DMA gating
	assign dma_rd_grant_o = dma_rd_req_i && st_reg.dma_read_enable;
	assign dma_wr_grant_o = dma_wr_req_i && st_reg.dma_write_enable;
endmodule
`default_nettype wire

// >>> rtl/ecd_host.sv
`timescale 1ns/1ps
`default_nettype none
// APB-controlled host: forwards register writes to the device, serves reads from copies it polls
module ecd_host (
	input wire logic clk_i,
	input wire logic reset_n_i,
	ecd_if.host bus,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic card_mode_i,
	input wire logic tx_halted_i,
	output logic irq_o
);
	import ecd_pkg::*;

	typedef struct packed {
		logic sel;
		logic wr;
		logic [1:0] addr;
		logic [7:0] wdata;
		logic [7:0] rd_pol;
		logic [7:0] rd_dma;
		logic halt_d;
		logic [1:0] irq_st;
		logic [1:0] irq_mask;
	} ecd_host_state_t;

	ecd_host_state_t st_reg, st_next;
	logic acc, hw, halt_rise;
	logic [7:0] safe;

	assign acc = psel && penable;
	assign hw = acc && pwrite;
	assign halt_rise = tx_halted_i && !st_reg.halt_d;

	always_comb begin
		st_next = st_reg;
		st_next.sel = 1'b0;
		st_next.wr = 1'b0;
		st_next.halt_d = tx_halted_i;
		st_next.rd_pol = bus.addr == ECD_OFF_POLICY ? bus.rdata : st_reg.rd_pol;
		st_next.rd_dma = bus.addr == ECD_OFF_DMA ? bus.rdata : st_reg.rd_dma;
		st_next.addr = st_reg.addr ^ 2'h1;
		// Sanitise writes: reserved bits zero, never both enables
		safe = {5'h00, pwdata[2:0]};
		if (pwdata[8]) begin
			safe = {4'h0, pwdata[11], 1'b0, 2'b00};
			if (!card_mode_i) begin
				safe[1:0] = pwdata[9] ? 2'b10 : {1'b0, pwdata[10]};
			end
		end
		if (hw && paddr == ECD_APB_CMD) begin
			st_next.sel = 1'b1;
			st_next.wr = 1'b1;
			st_next.addr = pwdata[8] ? ECD_OFF_DMA : ECD_OFF_POLICY;
			st_next.wdata = safe;
		end
		// Sticky events, write one to clear, set wins
		st_next.irq_st[0] = halt_rise ||
			(st_reg.irq_st[0] && !(hw && paddr == ECD_APB_IRQ_STATUS && pwdata[0]));
		// Second status bit has no event source yet and reads zero
		st_next.irq_st[1] = 1'b0;
		if (hw && paddr == ECD_APB_IRQ_MASK) begin
			st_next.irq_mask = pwdata[1:0];
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Device port driven from flops
	assign bus.sel = st_reg.sel;
	assign bus.wr = st_reg.wr;
	assign bus.addr = st_reg.addr;
	assign bus.wdata = st_reg.wdata;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign irq_o = |(st_reg.irq_st & st_reg.irq_mask);

	// Zero-wait read mux
	always_comb begin
		unique case (paddr)
			ECD_APB_STATUS: prdata = {15'h0000, tx_halted_i, st_reg.rd_dma, st_reg.rd_pol};
			ECD_APB_IRQ_STATUS: prdata = {30'h00000000, st_reg.irq_st};
			ECD_APB_IRQ_MASK: prdata = {30'h00000000, st_reg.irq_mask};
			default: prdata = 32'h00000000;
		endcase
	end
endmodule
`default_nettype wire

// >>> verification/ecd_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the byte port between host and device
module ecd_assertions (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic sel,
	input wire logic wr,
	input wire logic [1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata
);
	import ecd_pkg::*;
	logic [2:0] pol_q;
	logic [3:0] dma_q;
	wire logic wp = sel && wr && addr == ECD_OFF_POLICY;
	wire logic wd = sel && wr && addr == ECD_OFF_DMA;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// Shadow registers; a refused 11 lands as read only
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pol_q <= ECD_POLICY_RST[2:0];
			dma_q <= ECD_DMA_RST[3:0];
		end else begin
			if (wp) pol_q <= wdata[2:0];
			if (wd) dma_q <= {wdata[3], 1'h0, (wdata[1:0] == 2'h3) ? 2'h2 : wdata[1:0]};
		end
	end
	a_pol_upper_zero: assert property (addr == ECD_OFF_POLICY |-> rdata[7:3] == 5'h0)
		else $error("policy upper bits set");
	a_dma_resv_zero: assert property (addr == ECD_OFF_DMA |-> !rdata[2])
		else $error("dma bit 2 set");
	a_no_both_en: assert property (addr == ECD_OFF_DMA |-> rdata[1:0] != 2'h3)
		else $error("both enables set");
	a_pol_wr_clean: assert property (wp |-> wdata[7:3] == 5'h0)
		else $error("policy write dirty");
	a_dma_wr_clean: assert property (wd |-> wdata[7:4] == 4'h0 && !wdata[2])
		else $error("dma write dirty");
	a_pol_readback: assert property (addr == ECD_OFF_POLICY |-> rdata[2:0] == pol_q)
		else $error("policy readback wrong");
	a_dma_readback: assert property (addr == ECD_OFF_DMA |-> rdata[3:0] == dma_q)
		else $error("dma readback wrong");
	a_one_strobe: assert property (sel |=> !sel)
		else $error("strobe held");
	c_resume: cover property (wp && wdata[2:0] == ECD_POL_RESUME_SKIP);
	c_skip: cover property (wp && wdata[2:0] == ECD_POL_AUTO_SKIP);
	c_dma_off: cover property (wd && wdata[1:0] == 2'h0);
endmodule
`default_nettype wire

// >>> verification/excess_collision_and_dma_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module excess_collision_and_dma_control_tb;
	import ecd_pkg::*;
	logic clk_i = 1'h0, reset_n_i = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic ev = 1'h0, start = 1'h0, dend = 1'h0, rxv = 1'h0, done = 1'h0, card = 1'h0;
	logic [7:0] paddr = 8'h0;
	logic [10:0] len = 11'h0;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, irq, halted, dflag, acc, rej, rg, wg, i0;
	logic [1:0] act;
	logic [6:0] pend;
	int fails = 0, comparisons = 0;
	ecd_if bi ();
	ecd_device i_ecd_device (.clk_i, .reset_n_i, .bus(bi), .sixteen_collision_event_i(ev),
		.tx_done_i(done), .tx_start_i(start), .tx_count_i(7'h05), .dma_end_i(dend),
		.rx_len_valid_i(rxv), .rx_len_i(len), .dma_rd_req_i(1'h1), .dma_wr_req_i(1'h1),
		.tx_halted_o(halted), .collision_action_o(act), .pending_tx_count_o(pend),
		.dma_end_flag_o(dflag), .rx_accept_o(acc), .rx_reject_o(rej),
		.dma_rd_grant_o(rg), .dma_wr_grant_o(wg));
	ecd_host i_ecd_host (.clk_i, .reset_n_i, .bus(bi), .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .card_mode_i(card), .tx_halted_i(halted),
		.irq_o(irq));
	ecd_assertions i_ecd_assertions (.clk_i, .reset_n_i, .sel(bi.sel), .wr(bi.wr),
		.addr(bi.addr), .wdata(bi.wdata), .rdata(bi.rdata));
	// Clock
	initial forever #50 clk_i = ~clk_i;
	task chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task results;
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// APB transfer; held until pready is seen at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'h1;
		// Only the watchdog may end a wait for pready
		do begin
			@(posedge clk_i);
		end while (pready !== 1'h1);
		r = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task evp;
		@(posedge clk_i);
		ev <= 1'h1;
		@(posedge clk_i);
		ev <= 1'h0;
	endtask
	// Action code is a one-cycle pulse, so collect it over a window
	task wact(input logic [1:0] e);
		logic [1:0] g;
		g = 2'h0;
		// First look is just after the current edge, so a pulse launched there is seen
		repeat (8) begin
			#1;
			g = g | act;
			@(posedge clk_i);
		end
		chk(32'(g), 32'(e));
	endtask
	task rx(input logic [10:0] l, input logic [1:0] e);
		logic [1:0] g;
		g = 2'h0;
		@(posedge clk_i);
		rxv <= 1'h1;
		len <= l;
		@(posedge clk_i);
		rxv <= 1'h0;
		// Verdict pulse stands only for the cycle after the sampling edge
		repeat (4) begin
			#1;
			g = g | {rej, acc};
			@(posedge clk_i);
		end
		chk(32'(g), 32'(e));
	endtask
	task t_regs;
		apb(1'h0, ECD_APB_STATUS, 32'h0);
		chk(32'(r[15:0]), 32'h0);
		apb(1'h1, ECD_APB_CMD, 32'h500);
		cyc(2);
		chk(32'({rg, wg}), 32'h1);
		apb(1'h1, ECD_APB_CMD, 32'hf00);
		cyc(4);
		chk(32'({rg, wg}), 32'h2);
		apb(1'h0, ECD_APB_STATUS, 32'h0);
		chk(32'(r[15:8]), 32'h0a);
		apb(1'h0, 8'h40, 32'h0);
		evp;
		dend <= 1'h1;
		@(posedge clk_i);
		dend <= 1'h0;
		cyc(2);
		chk(32'(dflag), 32'h1);
		apb(1'h1, ECD_APB_CMD, 32'h900);
		cyc(3);
		chk(32'({dflag, rg, wg}), 32'h0);
		// Card mode: enable requests must be turned into zeros
		@(posedge clk_i);
		card <= 1'h1;
		apb(1'h1, ECD_APB_CMD, 32'h700);
		cyc(3);
		chk(32'({rg, wg}), 32'h0);
		@(posedge clk_i);
		card <= 1'h0;
		$display("regs done");
	endtask
	task t_rx;
		apb(1'h1, ECD_APB_CMD, 32'h100);
		rx(11'h700, 2'h2);
		rx(11'h6ff, 2'h1);
		apb(1'h1, ECD_APB_CMD, 32'h900);
		rx(11'h7ff, 2'h1);
		$display("rx done");
	endtask
	task t_auto;
		@(posedge clk_i);
		start <= 1'h1;
		apb(1'h1, ECD_APB_CMD, 32'(ECD_POL_AUTO_RETRY));
		start <= 1'h0;
		evp;
		wact(ECD_ACT_RETRY);
		chk(32'(pend), 32'h5);
		apb(1'h1, ECD_APB_CMD, 32'(ECD_POL_AUTO_SKIP));
		evp;
		wact(ECD_ACT_SKIP);
		chk(32'(pend), 32'h4);
		$display("auto done");
	endtask
	task t_manual;
		apb(1'h1, ECD_APB_CMD, 32'(ECD_POL_RESUME_RETRY));
		evp;
		cyc(3);
		chk(32'(halted), 32'h1);
		apb(1'h1, ECD_APB_IRQ_MASK, 32'h0);
		cyc(2);
		i0 = irq;
		apb(1'h1, ECD_APB_IRQ_MASK, 32'h1);
		cyc(2);
		chk(32'(i0 ^ irq), 32'h1);
		apb(1'h1, ECD_APB_CMD, 32'(ECD_POL_RESUME_SKIP));
		wact(ECD_ACT_SKIP);
		chk(32'({halted, pend}), 32'h3);
		apb(1'h1, ECD_APB_IRQ_STATUS, 32'h1);
		cyc(2);
		chk(32'(irq), 32'h0);
		evp;
		cyc(3);
		chk(32'(halted), 32'h1);
		apb(1'h1, ECD_APB_CMD, 32'(ECD_POL_RESUME_RETRY));
		wact(ECD_ACT_RETRY);
		chk(32'({halted, pend}), 32'h3);
		// A completed packet counts down as well
		@(posedge clk_i);
		done <= 1'h1;
		@(posedge clk_i);
		done <= 1'h0;
		cyc(2);
		chk(32'(pend), 32'h2);
		$display("manual done");
	endtask
	// Main sequence
	initial begin
		repeat (4) @(posedge clk_i);
		reset_n_i <= 1'h1;
		t_regs;
		t_rx;
		t_auto;
		t_manual;
		results;
	end
	// Watchdog well beyond the under two hundred cycles the tests need
	initial begin
		repeat (3000) @(posedge clk_i);
		fails++;
		results;
	end
endmodule
`default_nettype wire
